// File: verilog/mcs_monitor_select.sv
// monitor channel select and configuration write decoder
// assumes cmd_valid pulses once per decoded word, synchronous to sys_clk
// What this block does
// RL1: a word with both select bits low and address 1010 carries a monitor channel code.
// RL2: a source reaches the monitor output only while the probe enable bit is set.
// RL3: in 14-bit mode the code is data bits 13..8 and bits 7..0 are ignored.
// RL4: in 12-bit mode the code is data bits 11..6 and bits 5..0 are ignored.
// RL5: code 63 puts the monitor output in high impedance.
// RL6: codes 0..15 pick analog output channels, only 0..7 on the 8-channel build.
// RL7: code 100100 picks probe input 1 and code 100101 picks probe input 2.
// RL8: a word with both select bits low and address 1100 loads all 14 data bits as config.
// RL9: config bit 13 is the msb and bit 0 the lsb, matching data bits 13..0.
// RL10: special commands decode only when both select bits are zero.
// RL11: probe enable resets clear and while clear the output stays high impedance.
// RL12: the last accepted code is held until the next monitor command.
// RL13: after reset the stored code is all ones.
`timescale 1ns/10ps
`default_nettype none
module mcs_monitor_select
  import mcs_pkg::*;
#(
  parameter int NUM_CHANNELS = 16,
  parameter bit RES_12BIT    = 1'b0
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  input  wire logic                  cmd_valid,
  input  wire mcs_cmd_t              cmd,
  output logic [MCS_DATA_W-1:0]      device_configuration,
  output logic [MCS_CODE_W-1:0]      monitor_code,
  output mcs_route_t                 monitor_route,
  output logic                       monitor_output_oe
);
  localparam int CODE_LSB = RES_12BIT ? MCS_CODE_LSB_12 : MCS_CODE_LSB_14;

  logic                  sfr_hit;
  logic [MCS_DATA_W-1:0] next_config;
  logic [MCS_CODE_W-1:0] next_code;
  mcs_route_t            next_route;
  logic                  next_oe;

  // special function decode gate
  assign sfr_hit = cmd_valid && !cmd.register_select_high
                   && !cmd.register_select_low; // RL10

  // command decode and stored state
  always_comb begin
    next_config = device_configuration;
    next_code   = monitor_code;
    if (sfr_hit && cmd.command_address_field == MCS_ADDR_CONFIG) begin
      next_config = cmd.data; // RL8 RL9
    end
    if (sfr_hit && cmd.command_address_field == MCS_ADDR_MONITOR) begin
      next_code = cmd.data[CODE_LSB +: MCS_CODE_W]; // RL1 RL3 RL4
    end
  end // RL12

  // route decode from next state, registered to outputs
  always_comb begin
    next_route = '0;
    next_oe    = 1'b0;
    if (next_config[MCS_PROBE_EN_POS] && next_code != MCS_CODE_TRISTATE) begin // RL2 RL11 RL5
      if (next_code < MCS_CODE_W'(NUM_CHANNELS)) begin
        next_route.channel = next_code[3:0]; // RL6
        next_route.drive   = 1'b1;
      end else if (next_code == MCS_CODE_PROBE1) begin
        next_route.probe1  = 1'b1; // RL7
        next_route.drive   = 1'b1;
      end else if (next_code == MCS_CODE_PROBE2) begin
        next_route.probe2  = 1'b1; // RL7
        next_route.drive   = 1'b1;
      end
      next_oe = next_route.drive;
    end
  end

  // state registers
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      device_configuration <= MCS_CONFIG_RESET; // RL11
      monitor_code         <= MCS_CODE_TRISTATE; // RL13
      monitor_route        <= '0;
      monitor_output_oe    <= 1'b0;
    end else begin
      device_configuration <= next_config;
      monitor_code         <= next_code;
      monitor_route        <= next_route;
      monitor_output_oe    <= next_oe;
    end
  end

  // checks
  a_config_load: assert property (@(posedge sys_clk) disable iff (!rstn)
    sfr_hit && cmd.command_address_field == MCS_ADDR_CONFIG
    |=> device_configuration == $past(cmd.data)) // RL8
    else $error("config write not loaded");
  a_code_load: assert property (@(posedge sys_clk) disable iff (!rstn)
    sfr_hit && cmd.command_address_field == MCS_ADDR_MONITOR
    |=> monitor_code == $past(cmd.data[CODE_LSB +: MCS_CODE_W])) // RL3
    else $error("monitor code not captured");
  a_code_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
    !(sfr_hit && cmd.command_address_field == MCS_ADDR_MONITOR)
    |=> $stable(monitor_code)) // RL12
    else $error("monitor code changed without command");
  a_select_gate: assert property (@(posedge sys_clk) disable iff (!rstn)
    cmd_valid && (cmd.register_select_high || cmd.register_select_low)
    |=> $stable(monitor_code) && $stable(device_configuration)) // RL10
    else $error("non special word changed state");
  a_enable_gate: assert property (@(posedge sys_clk) disable iff (!rstn)
    !device_configuration[MCS_PROBE_EN_POS] |-> !monitor_output_oe) // RL11
    else $error("output driven while disabled");
  a_tristate_code: assert property (@(posedge sys_clk) disable iff (!rstn)
    monitor_code == MCS_CODE_TRISTATE |-> !monitor_output_oe) // RL5
    else $error("code 63 not high impedance");
  a_channel_route: assert property (@(posedge sys_clk) disable iff (!rstn)
    device_configuration[MCS_PROBE_EN_POS] && monitor_code < MCS_CODE_W'(NUM_CHANNELS)
    |-> monitor_output_oe && monitor_route.channel == monitor_code[3:0]) // RL6
    else $error("channel not routed");
  a_probe_route: assert property (@(posedge sys_clk) disable iff (!rstn)
    device_configuration[MCS_PROBE_EN_POS] && monitor_code == MCS_CODE_PROBE1
    |-> monitor_route.probe1 && !monitor_route.probe2 && monitor_output_oe) // RL7
    else $error("probe 1 not routed");
  a_reset_code: assert property (@(posedge sys_clk)
    !rstn |=> monitor_code == MCS_CODE_TRISTATE && !monitor_output_oe) // RL13
    else $error("reset code wrong");
  c_config: cover property (@(posedge sys_clk) disable iff (!rstn)
    sfr_hit && cmd.command_address_field == MCS_ADDR_CONFIG);
  c_channel: cover property (@(posedge sys_clk) disable iff (!rstn)
    monitor_output_oe && monitor_route.channel != 4'h0);
  c_probe2: cover property (@(posedge sys_clk) disable iff (!rstn) monitor_route.probe2);

  // second probe input reaches the monitor output on its own
  a_probe2_route: assert property (@(posedge sys_clk) disable iff (!rstn)
    device_configuration[MCS_PROBE_EN_POS] && monitor_code == MCS_CODE_PROBE2
    |-> monitor_route.probe2 && !monitor_route.probe1 && monitor_output_oe) // RL7
    else $error("probe 2 not routed");

  // codes with no source leave the output released
  a_unknown_code: assert property (@(posedge sys_clk) disable iff (!rstn)
    monitor_code >= MCS_CODE_W'(NUM_CHANNELS) && monitor_code != MCS_CODE_PROBE1
    && monitor_code != MCS_CODE_PROBE2
    |-> !monitor_output_oe && monitor_route == '0) // RL12
    else $error("undefined code drives output");

  // the drive flag and the pin enable always agree
  a_drive_match: assert property (@(posedge sys_clk) disable iff (!rstn)
    monitor_output_oe == monitor_route.drive) // RL2
    else $error("drive flag and enable differ");

  // never two probe inputs on the output at once
  a_probe_excl: assert property (@(posedge sys_clk) disable iff (!rstn)
    !(monitor_route.probe1 && monitor_route.probe2)) // RL7
    else $error("both probe inputs selected");

  // a released output carries no stale selection
  a_route_idle: assert property (@(posedge sys_clk) disable iff (!rstn)
    !monitor_output_oe |-> monitor_route == '0) // RL5
    else $error("route left set while released");

  // configuration comes out of reset cleared
  a_reset_config: assert property (@(posedge sys_clk)
    !rstn |=> device_configuration == MCS_CONFIG_RESET) // RL11
    else $error("config reset value wrong");

  // configuration holds unless a config word arrives
  a_config_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
    !(sfr_hit && cmd.command_address_field == MCS_ADDR_CONFIG)
    |=> $stable(device_configuration)) // RL9
    else $error("config changed without command");

  // a monitor word leaves the configuration alone
  a_monitor_cfg: assert property (@(posedge sys_clk) disable iff (!rstn)
    sfr_hit && cmd.command_address_field == MCS_ADDR_MONITOR
    |=> $stable(device_configuration)) // RL1
    else $error("monitor word touched config");

  // a config word leaves the stored code alone
  a_config_code: assert property (@(posedge sys_clk) disable iff (!rstn)
    sfr_hit && cmd.command_address_field == MCS_ADDR_CONFIG
    |=> $stable(monitor_code)) // RL8
    else $error("config word touched code");

  // a plain channel route only for codes inside the build
  a_channel_limit: assert property (@(posedge sys_clk) disable iff (!rstn)
    monitor_output_oe && !monitor_route.probe1 && !monitor_route.probe2
    |-> monitor_code < MCS_CODE_W'(NUM_CHANNELS)) // RL6
    else $error("channel routed beyond build");

  // per channel: enabled code c puts output channel c on the pin
  for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
    a_chan_select: assert property (@(posedge sys_clk) disable iff (!rstn)
      device_configuration[MCS_PROBE_EN_POS] && monitor_code == MCS_CODE_W'(ch)
      |-> monitor_output_oe && monitor_route.channel == 4'(ch)) // RL6
      else $error("channel select mismatch");
  end

  // further scenarios worth seeing
  c_probe1: cover property (@(posedge sys_clk) disable iff (!rstn)
    monitor_route.probe1);
  c_tristate: cover property (@(posedge sys_clk) disable iff (!rstn)
    device_configuration[MCS_PROBE_EN_POS] && monitor_code == MCS_CODE_TRISTATE);
endmodule // mcs_monitor_select
`default_nettype wire

// File: verilog/mcs_pkg.sv
// package for the monitor channel select command interpreter
// assumes a serial front end that delivers whole command words
package mcs_pkg;
  // command word fields
  localparam int          MCS_DATA_W        = 14;
  localparam int          MCS_CODE_W        = 6;
  localparam logic [3:0]  MCS_ADDR_MONITOR  = 4'hA;
  localparam logic [3:0]  MCS_ADDR_CONFIG   = 4'hC;
  // channel code positions per resolution
  localparam int          MCS_CODE_LSB_14   = 8;
  localparam int          MCS_CODE_LSB_12   = 6;
  // monitor codes
  localparam logic [5:0]  MCS_CODE_TRISTATE = 6'h3F;
  localparam logic [5:0]  MCS_CODE_PROBE1   = 6'h24;
  localparam logic [5:0]  MCS_CODE_PROBE2   = 6'h25;
  // configuration register
  localparam int          MCS_PROBE_EN_POS  = 9;
  localparam logic [13:0] MCS_CONFIG_RESET  = 14'h0000;

  // one incoming command word
  typedef struct packed {
    logic       register_select_high;
    logic       register_select_low;
    logic [3:0] command_address_field;
    logic [13:0] data;
  } mcs_cmd_t;

  // multiplexer selection handed to the analog switch
  typedef struct packed {
    logic       drive;
    logic       probe1;
    logic       probe2;
    logic [3:0] channel;
  } mcs_route_t;
endpackage

// File: tb/mcs_host_model.sv
// host model that sends command words to the monitor select decoder
// assumes inputs change 1 ns after the rising edge of sys_clk
`timescale 1ns/10ps
`default_nettype none
module mcs_host_model
  import mcs_pkg::*;
(
  input  wire logic sys_clk,
  output logic      cmd_valid,
  output mcs_cmd_t  cmd
);
  // idle at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd       = '0;
  end
  // one word per edge; an idle cycle inverts the previous bus value, so two idles in a row show the earlier word again
  task automatic issue(input logic vld, input mcs_cmd_t w);
    @(posedge sys_clk);
    #1;
    cmd_valid = vld;
    cmd       = vld ? w : ~cmd;
  endtask
endmodule // mcs_host_model
`default_nettype wire

// File: tb/mcs_monitor_select_tb.sv
// self-checking bench for the monitor select decoder
// assumes the host model drives commands and the bench predicts outputs
`timescale 1ns/10ps
`default_nettype none
module mcs_monitor_select_tb
  import mcs_pkg::*;
;
  localparam int NCH = 16;
  logic        sys_clk;
  logic        rstn;
  logic        cmd_valid;
  mcs_cmd_t    cmd;
  logic [13:0] cfg;
  logic [5:0]  code;
  mcs_route_t  route;
  logic        oe;
  logic [13:0] cfg12;
  logic [5:0]  code12;
  mcs_route_t  route12;
  logic        oe12;
  logic [5:0]  e_code12;
  logic [13:0] e_cfg;
  logic [5:0]  e_code;
  logic [31:0] r;
  mcs_cmd_t    w;
  logic        v;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          seed = 95;
  mcs_host_model i_host (.sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd(cmd));
  mcs_monitor_select #(.NUM_CHANNELS(NCH), .RES_12BIT(1'b0)) i_dut (
    .sys_clk(sys_clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd(cmd),
    .device_configuration(cfg), .monitor_code(code), .monitor_route(route),
    .monitor_output_oe(oe));
  // 12-bit, 8-channel build on the same command stream
  mcs_monitor_select #(.NUM_CHANNELS(8), .RES_12BIT(1'b1)) i_dut_12 (
    .sys_clk(sys_clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd(cmd),
    .device_configuration(cfg12), .monitor_code(code12), .monitor_route(route12),
    .monitor_output_oe(oe12));
  // 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // expected {oe, probe1, probe2, channel}
  function automatic logic [6:0] exp_out(input logic [13:0] c, input logic [5:0] k,
                                         input int nch);
    if (!c[MCS_PROBE_EN_POS]) return 7'h00;
    if (k < nch) return {3'b100, k[3:0]};
    if (k == MCS_CODE_PROBE1) return 7'h60;
    if (k == MCS_CODE_PROBE2) return 7'h50;
    return 7'h00;
  endfunction
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_outputs();
    chk({6'h00, cfg}, {6'h00, e_cfg});
    chk({14'h0000, code}, {14'h0000, e_code});
    chk({13'h0000, oe, route[5:0]}, {13'h0000, exp_out(e_cfg, e_code, NCH)});
    chk({13'h0000, route[6:0]}, {13'h0000, exp_out(e_cfg, e_code, NCH)});
    chk({6'h00, cfg12}, {6'h00, e_cfg});
    chk({14'h0000, code12}, {14'h0000, e_code12});
    chk({13'h0000, oe12, route12[5:0]}, {13'h0000, exp_out(e_cfg, e_code12, 8)});
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // reset, corner words, then random traffic with about one idle cycle in four
  initial begin
    rstn = 1'b0;
    repeat (8) @(posedge sys_clk);
    #1 rstn = 1'b1;
    e_cfg  = MCS_CONFIG_RESET;
    e_code = MCS_CODE_TRISTATE;
    e_code12 = MCS_CODE_TRISTATE;
    check_outputs();
    for (int i = 0; i < 800; i++) begin
      r = $random(seed);
      v = (i < 2) || (r[1:0] != 2'b00);
      w.register_select_high = (r[4:2] == 3'h0) ? r[5] : 1'b0;
      w.register_select_low  = (r[4:2] == 3'h0) ? r[6] : 1'b0;
      w.command_address_field = r[8] ? MCS_ADDR_MONITOR : r[9] ? MCS_ADDR_CONFIG : r[13:10];
      case (r[16:14])
        3'h0: w.data = {MCS_CODE_PROBE1, r[31:24]};
        3'h1: w.data = {MCS_CODE_PROBE2, r[31:24]};
        3'h2: w.data = {MCS_CODE_TRISTATE, r[31:24]};
        3'h3: w.data = r[31:18];
        default: w.data = {2'b00, r[20:17], r[31:24]};
      endcase
      if (w.command_address_field == MCS_ADDR_CONFIG) w.data = r[31:18];
      // host enables probing first, then selects channel 3 on the 14-bit build and code 15, with no source, on the 12-bit build
      if (i == 0) w = {2'b00, MCS_ADDR_CONFIG, 14'h0200};
      if (i == 1) w = {2'b00, MCS_ADDR_MONITOR, 14'h03FF};
      i_host.issue(v, w);
      check_outputs();
      if (v && !w.register_select_high && !w.register_select_low) begin
        if (w.command_address_field == MCS_ADDR_CONFIG) e_cfg = w.data;
        if (w.command_address_field == MCS_ADDR_MONITOR) e_code = w.data[13:8];
        if (w.command_address_field == MCS_ADDR_MONITOR) e_code12 = w.data[11:6];
      end
    end
    i_host.issue(1'b0, w);
    check_outputs();
    complete_run();
  end
endmodule // mcs_monitor_select_tb
`default_nettype wire
